// file: rtl/amp_fault_params.svh
// Register offsets, field positions, reset values and bit layouts
// Assumes inclusion by the protection and fault monitor module
`ifndef AMP_FAULT_PARAMS_SVH
`define AMP_FAULT_PARAMS_SVH

// Register offsets
`define OFS_STATE_CONTROL      8'h00
`define OFS_MISC_CONTROL_ONE   8'h01
`define OFS_MISC_CONTROL_THREE 8'h21
`define OFS_CLIP_WINDOW_COUNT  8'h23
`define OFS_CURRENT_LIMIT_STAT 8'h25
`define OFS_GLOBAL_FAULT_STAT  8'h30
`define OFS_CHANNEL_FAULT_STAT 8'h31
`define OFS_WARNING_STAT       8'h32
`define OFS_PIN_MASK           8'h33
`define OFS_PROTECT_CONFIG     8'h34

// Reset values
`define RST_STATE_CONTROL      8'h00
`define RST_MISC_CONTROL_ONE   8'h00
`define RST_MISC_CONTROL_THREE 8'h00
`define RST_CLIP_WINDOW_COUNT  8'h14
`define RST_PIN_MASK           8'h00
`define RST_PROTECT_CONFIG     8'h02

// Field positions
`define BIT_CURRENT_LEVEL_SEL  4
`define BIT_WARN_LEVEL_LO      5
`define BIT_WARN_LEVEL_HI      6
`define BIT_AUTO_RECOVER       3
`define BIT_ERROR_CLEAR        7
`define BIT_CLIP_NONLATCH      0
`define BIT_DIAG_ENABLE        1

// Pin mask bits
`define MASK_CLIP              0
`define MASK_CURRENT_CLAMP     1
`define MASK_THERMAL_WARNING   2
`define MASK_DC_OFFSET         3
`define MASK_OVERCURRENT       4
`define MASK_THERMAL_SHUTDOWN  5
`define MASK_SUPPLY            6
`define MASK_CLOCK_ERROR       7

// Sticky flag vector layout
`define FLG_SUPPLY_LOW_PS      0
`define FLG_SUPPLY_LOW_BAT     1
`define FLG_SUPPLY_HIGH        2
`define FLG_THERMAL_SHUTDOWN   3
`define FLG_CLOCK_ERROR        4
`define FLG_OVERCURRENT_TRIP   5
`define FLG_DC_OFFSET          6
`define FLG_CH_THERMAL_SHUT    7
`define FLG_RESET_WARNING      8
`define FLG_CLIP               9
`define FLG_THERMAL_WARNING    10
`define FLG_CH_THERMAL_WARNING 11
`define FLG_CURRENT_CLAMP      12
`define FLG_COUNT              13

`endif

// file: rtl/amp_fault_pkg.sv
// Types shared by the protection and fault monitor modules
// Assumes the analog comparators deliver levels synchronous to ref_clk
package amp_fault_pkg;

  // Comparator and sensor levels from the analog side
  typedef struct packed {
    logic       current_clamp_lo;
    logic       current_clamp_hi;
    logic       overcurrent_trip_lo;
    logic       overcurrent_trip_hi;
    logic       dc_offset_high;
    logic       pwm_full_duty;
    logic       pwm_cycle_tick;
    logic [3:0] thermal_warning_lvl;
    logic       thermal_shutdown;
    logic       channel_thermal_warning;
    logic       channel_thermal_shutdown;
    logic       power_stage_supply_low;
    logic       battery_supply_low;
    logic       supply_high;
    logic       clock_error;
  } sense_type;

  // Register access from the serial slave
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  // Channel output stage command
  typedef enum logic [1:0] {
    drive_hiz,
    drive_mute,
    drive_play
  } drive_type;

  // Overcurrent recovery sequence
  typedef enum logic [1:0] {
    oc_run,
    oc_tripped,
    oc_diag_start,
    oc_diag_wait
  } oc_state_type;

endpackage

// file: rtl/sticky_flags.sv
// Bank of sticky flags set by hardware events, cleared by one pulse
// Assumes set and clear are synchronous to ref_clk
`timescale 1ns/1ns
module sticky_flags #(
  parameter int WIDTH = 13
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] set_in,
  input  wire logic             clear,
  output logic      [WIDTH-1:0] flags_r
);

  // Set beats clear so an event in the clear cycle is never lost
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : gen_flag
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          flags_r[g] <= 1'b0;
        end else if (set_in[g]) begin
          flags_r[g] <= 1'b1;
        end else if (clear) begin
          flags_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule // sticky_flags

// file: rtl/clip_detector.sv
// Counts consecutive full-duty PWM cycles against the clip window
// Assumes one tick per PWM cycle and a full-duty level from the modulator
`timescale 1ns/1ns
module clip_detector (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       full_duty,
  input  wire logic       cycle_tick,
  input  wire logic [7:0] window,
  output logic            clip_r
);

  logic [7:0] run_r;
  logic [7:0] run_nxt;

  // Run length of full-duty cycles, saturating at the top
  always_comb begin
    run_nxt = run_r;
    if (!full_duty) begin
      run_nxt = 8'h00;
    end else if (cycle_tick && run_r != 8'hff) begin
      run_nxt = run_r + 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      run_r <= 8'h00;
    end else begin
      run_r <= run_nxt;
    end
  end

  // Live clip level; drops as soon as duty falls below full
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      clip_r <= 1'b0;
    end else begin
      clip_r <= full_duty && (run_nxt >= window);
    end
  end

endmodule // clip_detector

// file: rtl/amp_protection_fault_monitor.sv
// Protection and fault monitor for a one-channel class-D amplifier
// Assumes a serial slave delivers register accesses as reg_req pulses
// What this block does
// - Current clamp cuts PWM pulses, reports warning pin and status only
// - Misc control one bit 4 selects between two current thresholds
// - Overcurrent trip: Hi-Z, fault bit, error pin, held until clear
// - After clear with diagnostics on, run diagnostics until load is good
// - Diagnostics off: stay Hi-Z until host clears after fault removed
// - DC offset over threshold: Hi-Z, fault bit, error pin
// - Mask bit can keep DC offset fault off the error pin
// - Clip warns once full duty lasts the clip window, pin maskable
// - Clip latches by default; non-latching mode follows the live clip level
// - Four selectable thermal warning levels drive alert pin unless masked
// - Thermal shutdown goes Hi-Z; auto-recovery bit restores state control
// - In auto-recovery the error pin still waits for the clear bit
// - Channel thermal warning sets warning bit and alert pin unless masked
// - Channel thermal shutdown Hi-Z, recovers below warning if auto-recovery
// - Supply low on either rail sets status and error pin
// - Reset restores all defaults, sets reset warning and alert pin
// - Power-stage supply high sets status and error pin
// - Error pin is active low for all listed fault categories
// - Error pin holds until clear, thermal auto-recovery included
// - Every fault report stays set until the clear bit is written
// - Masks gate only the pins; all categories reach pins after reset
// - Alert pin latches until the clear bit, except non-latching clip, which drives it live
`timescale 1ns/1ns
`include "amp_fault_params.svh"
module amp_protection_fault_monitor
  import amp_fault_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire sense_type   sense,
  input  wire reg_req_type reg_req,
  input  wire logic        diag_done,
  input  wire logic        diag_load_fault,
  output logic [7:0]       rd_data_r,
  output logic             rd_valid_r,
  output logic             serial_release_r,
  output drive_type        channel_drive_r,
  output logic             pulse_cut_r,
  output logic             diag_start_r,
  output logic             error_flag_n_out,
  output logic             error_flag_n_oe,
  output logic             alert_flag_n_out,
  output logic             alert_flag_n_oe
);

  // Pick one of two comparator levels by a select bit
  function automatic logic pick2(input logic sel, input logic lo,
                                 input logic hi);
    pick2 = sel ? hi : lo;
  endfunction

  // Decode the state control field into a drive command
  function automatic drive_type decode_drive(input logic [1:0] code);
    if (code == 2'h2) begin
      decode_drive = drive_play;
    end else if (code == 2'h1) begin
      decode_drive = drive_mute;
    end else begin
      decode_drive = drive_hiz;
    end
  endfunction

  logic [7:0]           state_control_r;
  logic [7:0]           misc_control_one_r;
  logic [7:0]           misc_control_three_r;
  logic [7:0]           clip_window_count_r;
  logic [7:0]           pin_mask_r;
  logic [7:0]           protect_config_r;
  logic                 clear_pulse_r;
  logic                 por_pending_r;
  logic [`FLG_COUNT-1:0] flag_set;
  logic [`FLG_COUNT-1:0] flags_r;
  logic                 clip_live_r;
  logic                 clamp_hit;
  logic                 trip_hit;
  logic                 warn_hit;
  logic                 auto_recover;
  logic                 clip_nonlatch;
  logic                 thermal_hold_r;
  logic                 channel_thermal_hold_r;
  logic                 dc_hold_r;
  oc_state_type         oc_state_r;
  oc_state_type         oc_state_nxt;
  logic                 error_latch_r;
  logic                 alert_latch_r;
  logic                 error_event;
  logic                 alert_event;
  logic                 supply_bad;
  logic [7:0]           rd_nxt;

  // Configuration fields
  assign auto_recover  = misc_control_three_r[`BIT_AUTO_RECOVER];
  assign clip_nonlatch = protect_config_r[`BIT_CLIP_NONLATCH];

  // Threshold selection for clamp, trip and warning level
  assign clamp_hit = pick2(misc_control_one_r[`BIT_CURRENT_LEVEL_SEL],
                           sense.current_clamp_lo,
                           sense.current_clamp_hi);
  assign trip_hit  = pick2(misc_control_one_r[`BIT_CURRENT_LEVEL_SEL],
                           sense.overcurrent_trip_lo,
                           sense.overcurrent_trip_hi);
  assign warn_hit  = sense.thermal_warning_lvl[
                       misc_control_one_r[`BIT_WARN_LEVEL_HI:
                                          `BIT_WARN_LEVEL_LO]];
  assign supply_bad = sense.power_stage_supply_low |
                      sense.battery_supply_low | sense.supply_high;

  // Register writes; the clear bit never stores, it only fires a pulse
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_control_r      <= `RST_STATE_CONTROL;
      misc_control_one_r   <= `RST_MISC_CONTROL_ONE;
      misc_control_three_r <= `RST_MISC_CONTROL_THREE;
      clip_window_count_r  <= `RST_CLIP_WINDOW_COUNT;
      pin_mask_r           <= `RST_PIN_MASK;
      protect_config_r     <= `RST_PROTECT_CONFIG;
    end else if (reg_req.wr) begin
      if (reg_req.addr == `OFS_STATE_CONTROL) begin
        state_control_r <= reg_req.wdata;
      end else if (reg_req.addr == `OFS_MISC_CONTROL_ONE) begin
        misc_control_one_r <= reg_req.wdata;
      end else if (reg_req.addr == `OFS_MISC_CONTROL_THREE) begin
        misc_control_three_r <= reg_req.wdata & 8'h7f;
      end else if (reg_req.addr == `OFS_CLIP_WINDOW_COUNT) begin
        clip_window_count_r <= reg_req.wdata;
      end else if (reg_req.addr == `OFS_PIN_MASK) begin
        pin_mask_r <= reg_req.wdata;
      end else if (reg_req.addr == `OFS_PROTECT_CONFIG) begin
        protect_config_r <= reg_req.wdata;
      end
    end
  end

  // One-cycle clear pulse from a write of the clear bit
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      clear_pulse_r <= 1'b0;
    end else begin
      clear_pulse_r <= reg_req.wr &&
                       reg_req.addr == `OFS_MISC_CONTROL_THREE &&
                       reg_req.wdata[`BIT_ERROR_CLEAR];
    end
  end

  // Reset warning is raised on the first cycle after reset release
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      por_pending_r <= 1'b1;
    end else begin
      por_pending_r <= 1'b0;
    end
  end

  // Serial interface stays released while reset holds
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      serial_release_r <= 1'b1;
    end else begin
      serial_release_r <= 1'b0;
    end
  end

  clip_detector u_clip (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .full_duty  (sense.pwm_full_duty),
    .cycle_tick (sense.pwm_cycle_tick),
    .window     (clip_window_count_r),
    .clip_r     (clip_live_r)
  );

  // Events feeding the sticky reports
  always_comb begin
    flag_set = '0;
    flag_set[`FLG_SUPPLY_LOW_PS]      = sense.power_stage_supply_low;
    flag_set[`FLG_SUPPLY_LOW_BAT]     = sense.battery_supply_low;
    flag_set[`FLG_SUPPLY_HIGH]        = sense.supply_high;
    flag_set[`FLG_THERMAL_SHUTDOWN]   = sense.thermal_shutdown;
    flag_set[`FLG_CLOCK_ERROR]        = sense.clock_error;
    flag_set[`FLG_OVERCURRENT_TRIP]   = trip_hit;
    flag_set[`FLG_DC_OFFSET]          = sense.dc_offset_high;
    flag_set[`FLG_CH_THERMAL_SHUT]    = sense.channel_thermal_shutdown;
    flag_set[`FLG_RESET_WARNING]      = por_pending_r;
    flag_set[`FLG_CLIP]               = clip_live_r;
    flag_set[`FLG_THERMAL_WARNING]    = warn_hit;
    flag_set[`FLG_CH_THERMAL_WARNING] = sense.channel_thermal_warning;
    flag_set[`FLG_CURRENT_CLAMP]      = clamp_hit;
  end

  // All reports hold until the clear pulse
  sticky_flags #(
    .WIDTH (`FLG_COUNT)
  ) u_flags (
    .ref_clk (ref_clk),
    .reset   (reset),
    .set_in  (flag_set),
    .clear   (clear_pulse_r),
    .flags_r (flags_r)
  );

  // Clamp cuts the current PWM pulse and keeps the channel running
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pulse_cut_r <= 1'b0;
    end else begin
      pulse_cut_r <= clamp_hit;
    end
  end

  // Overcurrent recovery: trip, wait for clear, optional diagnostics
  always_comb begin
    oc_state_nxt = oc_state_r;
    case (oc_state_r)
      oc_run: begin
        if (trip_hit) begin
          oc_state_nxt = oc_tripped;
        end
      end
      oc_tripped: begin
        if (clear_pulse_r && !trip_hit) begin
          if (protect_config_r[`BIT_DIAG_ENABLE]) begin
            oc_state_nxt = oc_diag_start;
          end else begin
            oc_state_nxt = oc_run;
          end
        end
      end
      oc_diag_start: begin
        oc_state_nxt = oc_diag_wait;
      end
      oc_diag_wait: begin
        if (diag_done) begin
          if (diag_load_fault) begin
            oc_state_nxt = oc_diag_start;
          end else begin
            oc_state_nxt = oc_run;
          end
        end
      end
      default: begin
        oc_state_nxt = oc_tripped;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      oc_state_r <= oc_run;
    end else begin
      oc_state_r <= oc_state_nxt;
    end
  end

  // Diagnostics request pulse, one per diagnostics pass
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      diag_start_r <= 1'b0;
    end else begin
      diag_start_r <= (oc_state_nxt == oc_diag_start);
    end
  end

  // DC offset holds the channel off until the clear pulse
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dc_hold_r <= 1'b0;
    end else if (sense.dc_offset_high) begin
      dc_hold_r <= 1'b1;
    end else if (clear_pulse_r) begin
      dc_hold_r <= 1'b0;
    end
  end

  // Global thermal shutdown: latched, or released once cool if recovering
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      thermal_hold_r <= 1'b0;
    end else if (sense.thermal_shutdown) begin
      thermal_hold_r <= 1'b1;
    end else if (auto_recover || clear_pulse_r) begin
      thermal_hold_r <= 1'b0;
    end
  end

  // Channel shutdown auto-recovers only below the channel warning level
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      channel_thermal_hold_r <= 1'b0;
    end else if (sense.channel_thermal_shutdown) begin
      channel_thermal_hold_r <= 1'b1;
    end else if ((auto_recover && !sense.channel_thermal_warning) ||
                 clear_pulse_r) begin
      channel_thermal_hold_r <= 1'b0;
    end
  end

  // Any hold forces Hi-Z; otherwise follow the state control register.
  // Masks are not consulted here, so protection never depends on them.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      channel_drive_r <= drive_hiz;
    end else if (oc_state_r != oc_run || trip_hit || dc_hold_r ||
                 sense.dc_offset_high || thermal_hold_r ||
                 sense.thermal_shutdown || channel_thermal_hold_r ||
                 sense.channel_thermal_shutdown || supply_bad) begin
      channel_drive_r <= drive_hiz;
    end else begin
      channel_drive_r <= decode_drive(state_control_r[1:0]);
    end
  end

  // Unmasked fault categories for the error pin
  assign error_event =
    (trip_hit && !pin_mask_r[`MASK_OVERCURRENT]) ||
    (sense.dc_offset_high && !pin_mask_r[`MASK_DC_OFFSET]) ||
    ((sense.thermal_shutdown || sense.channel_thermal_shutdown) &&
     !pin_mask_r[`MASK_THERMAL_SHUTDOWN]) ||
    (supply_bad && !pin_mask_r[`MASK_SUPPLY]) ||
    (sense.clock_error && !pin_mask_r[`MASK_CLOCK_ERROR]);

  // Unmasked warnings for the alert pin; clamp never reaches error pin
  assign alert_event =
    por_pending_r ||
    (clamp_hit && !pin_mask_r[`MASK_CURRENT_CLAMP]) ||
    (clip_live_r && !clip_nonlatch &&
     !pin_mask_r[`MASK_CLIP]) ||
    ((warn_hit || sense.channel_thermal_warning) &&
     !pin_mask_r[`MASK_THERMAL_WARNING]);

  // Error latch holds through thermal auto-recovery until the clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      error_latch_r <= 1'b0;
    end else if (error_event) begin
      error_latch_r <= 1'b1;
    end else if (clear_pulse_r) begin
      error_latch_r <= 1'b0;
    end
  end

  // Alert latch; the reset warning makes it start asserted
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      alert_latch_r <= 1'b1;
    end else if (alert_event) begin
      alert_latch_r <= 1'b1;
    end else if (clear_pulse_r) begin
      alert_latch_r <= 1'b0;
    end
  end

  // Open-drain error pin: drive low from the event until the clear pulse
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      error_flag_n_out <= 1'b0;
      error_flag_n_oe  <= 1'b0;
    end else begin
      error_flag_n_out <= 1'b0;
      error_flag_n_oe  <= error_latch_r || error_event;
    end
  end

  // Non-latching clip follows the live level, outside the alert latch
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      alert_flag_n_out <= 1'b0;
      alert_flag_n_oe  <= 1'b0;
    end else begin
      alert_flag_n_out <= 1'b0;
      alert_flag_n_oe  <= alert_latch_r || alert_event ||
                          (clip_live_r && clip_nonlatch &&
                           !pin_mask_r[`MASK_CLIP]);
    end
  end

  // Read multiplexer; unmapped offsets read zero
  always_comb begin
    rd_nxt = 8'h00;
    if (reg_req.addr == `OFS_STATE_CONTROL) begin
      rd_nxt = state_control_r;
    end else if (reg_req.addr == `OFS_MISC_CONTROL_ONE) begin
      rd_nxt = misc_control_one_r;
    end else if (reg_req.addr == `OFS_MISC_CONTROL_THREE) begin
      rd_nxt = misc_control_three_r;
    end else if (reg_req.addr == `OFS_CLIP_WINDOW_COUNT) begin
      rd_nxt = clip_window_count_r;
    end else if (reg_req.addr == `OFS_CURRENT_LIMIT_STAT) begin
      rd_nxt = {7'h00, flags_r[`FLG_CURRENT_CLAMP]};
    end else if (reg_req.addr == `OFS_GLOBAL_FAULT_STAT) begin
      rd_nxt = {3'h0, flags_r[`FLG_CLOCK_ERROR:`FLG_SUPPLY_LOW_PS]};
    end else if (reg_req.addr == `OFS_CHANNEL_FAULT_STAT) begin
      rd_nxt = {5'h00,
                flags_r[`FLG_CH_THERMAL_SHUT:`FLG_OVERCURRENT_TRIP]};
    end else if (reg_req.addr == `OFS_WARNING_STAT) begin
      rd_nxt = {4'h0, flags_r[`FLG_CH_THERMAL_WARNING],
                flags_r[`FLG_THERMAL_WARNING],
                clip_nonlatch ? clip_live_r : flags_r[`FLG_CLIP],
                flags_r[`FLG_RESET_WARNING]};
    end else if (reg_req.addr == `OFS_PIN_MASK) begin
      rd_nxt = pin_mask_r;
    end else if (reg_req.addr == `OFS_PROTECT_CONFIG) begin
      rd_nxt = protect_config_r;
    end
  end

  // Read data registered one cycle after the read strobe
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_data_r  <= 8'h00;
      rd_valid_r <= 1'b0;
    end else begin
      rd_data_r  <= reg_req.rd ? rd_nxt : rd_data_r;
      rd_valid_r <= reg_req.rd;
    end
  end

endmodule // amp_protection_fault_monitor

// file: test/amp_fault_assertions.sv
// Port checker for the protection and fault monitor
// Assumes it is bound to amp_protection_fault_monitor
`timescale 1ns/1ns
module amp_fault_assertions
  import amp_fault_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire sense_type   sense,
  input wire reg_req_type reg_req,
  input wire logic [7:0]  rd_data_r,
  input wire logic        rd_valid_r,
  input wire logic        serial_release_r,
  input wire drive_type   channel_drive_r,
  input wire logic        pulse_cut_r,
  input wire logic        error_flag_n_oe,
  input wire logic        alert_flag_n_oe
);
  logic [2:0] since_clr_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Cycles since a clear write; saturates so old clears stop counting
  always_ff @(posedge ref_clk) begin
    if (reset)
      since_clr_r <= 3'h7;
    else if (reg_req.wr && reg_req.addr == 8'h21 && reg_req.wdata[7])
      since_clr_r <= 3'h0;
    else if (since_clr_r != 3'h7)
      since_clr_r <= since_clr_r + 3'h1;
  end
  AST_TRIP: assert property (
    sense.overcurrent_trip_lo && sense.overcurrent_trip_hi |=>
    channel_drive_r == drive_hiz && error_flag_n_oe) else $error("trip");
  AST_FAULT_HIZ: assert property (
    sense.dc_offset_high || sense.thermal_shutdown || sense.supply_high
    |=> channel_drive_r == drive_hiz) else $error("fault not hiz");
  AST_CLAMP: assert property (
    sense.current_clamp_lo && sense.current_clamp_hi |=> pulse_cut_r)
    else $error("clamp not cut");
  AST_RST_SERIAL: assert property (
    $fell(reset) |-> serial_release_r) else $error("serial not hiz");
  AST_RST_ALERT: assert property (
    $fell(reset) |-> ##[0:2] alert_flag_n_oe) else $error("no alert");
  AST_CLR_ZERO: assert property (
    reg_req.rd && reg_req.addr == 8'h21 |=> rd_valid_r && !rd_data_r[7])
    else $error("clear bit reads one");
  AST_ERR_HOLD: assert property (
    $fell(error_flag_n_oe) |-> since_clr_r < 3'h5)
    else $error("error pin fell unasked");
  AST_RD_ANS: assert property (
    rd_valid_r == $past(reg_req.rd)) else $error("rd valid");
endmodule // amp_fault_assertions

bind amp_protection_fault_monitor amp_fault_assertions chk_i (.*);

// file: test/host_model.sv
// Host side of the register port: one command becomes one strobe
// Assumes the bench idles cmd between accesses
`timescale 1ns/1ns
module host_model
  import amp_fault_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire reg_req_type cmd,
  output reg_req_type      reg_req
);
  // Launch just after the edge so the slave sees a clean cycle
  always_ff @(posedge ref_clk) reg_req <= cmd;
endmodule // host_model

// file: test/tb_amp_protection_fault_monitor.sv
// Bench for the protection and fault monitor
// Assumes host_model and the bound checker are compiled alongside
`timescale 1ns/1ns
module tb_amp_protection_fault_monitor
  import amp_fault_pkg::*;
;
  logic        ref_clk, reset, eo, ao, rd_valid_r, pulse_cut_r;
  logic        dd, dl, diag_st;
  sense_type   s;
  reg_req_type cmd, reg_req;
  logic [7:0]  rd_data_r;
  drive_type   drv;
  int          n_mismatch, tests_run, cyc;
  // Address and reset value pairs; 8'h7f is unmapped
  logic [15:0] rows [9] = '{16'h0000, 16'h0100, 16'h2100, 16'h2314,
    16'h2500, 16'h3300, 16'h3402, 16'h3201, 16'h7f00};
  host_model host (.ref_clk, .cmd, .reg_req);
  amp_protection_fault_monitor dut (.ref_clk, .reset, .sense(s),
    .reg_req, .diag_done(dd), .diag_load_fault(dl), .rd_data_r,
    .rd_valid_r, .serial_release_r(), .channel_drive_r(drv),
    .pulse_cut_r, .diag_start_r(diag_st), .error_flag_n_out(),
    .error_flag_n_oe(eo), .alert_flag_n_out(), .alert_flag_n_oe(ao));
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  // One access; returns once the answer has landed
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
    cmd = '{wr:w, rd:!w, addr:a, wdata:d};
    @(negedge ref_clk) cmd = '0;
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk("rd_data", e, rd_data_r);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Free-running clock and a hang guard
  initial begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 3000) begin
      n_mismatch++;
      conclude();
    end
  end
  // Main sequence; inputs move on falling edges only
  initial begin
    s = '0;
    {dd, dl} = 2'b00;
    cmd = '0;
    reset = 1;
    repeat (5) @(negedge ref_clk);
    reset = 0;
    @(negedge ref_clk);
    foreach (rows[i]) rd(rows[i][15:8], rows[i][7:0]);
    $display("reset values done");
    acc(1, 8'h34, 8'h00);
    acc(1, 8'h00, 8'h02);
    s.overcurrent_trip_lo = 1;
    @(negedge ref_clk) s.overcurrent_trip_lo = 0;
    repeat (3) @(negedge ref_clk);
    chk("drive", drive_hiz, 8'(drv));
    rd(8'h31, 8'h01);
    chk("err", 1, eo);
    chk("alert", 1, ao);
    acc(1, 8'h21, 8'h80);
    repeat (3) @(negedge ref_clk);
    chk("err", 0, eo);
    chk("alert", 0, ao);
    chk("drive", drive_play, 8'(drv));
    rd(8'h31, 8'h00);
    rd(8'h21, 8'h00);
    $display("overcurrent done");
    s.current_clamp_lo = 1;
    repeat (2) @(negedge ref_clk);
    chk("cut", 1, pulse_cut_r);
    chk("drive", drive_play, 8'(drv));
    chk("err", 0, eo);
    chk("alert", 1, ao);
    acc(1, 8'h01, 8'h10);
    chk("cut", 0, pulse_cut_r);
    s.current_clamp_hi = 1;
    repeat (2) @(negedge ref_clk);
    chk("cut", 1, pulse_cut_r);
    {s.current_clamp_lo, s.current_clamp_hi} = 2'b00;
    rd(8'h25, 8'h01);
    $display("clamp done");
    acc(1, 8'h33, 8'h08);
    s.dc_offset_high = 1;
    @(negedge ref_clk) s.dc_offset_high = 0;
    repeat (2) @(negedge ref_clk);
    chk("err", 0, eo);
    chk("drive", drive_hiz, 8'(drv));
    rd(8'h31, 8'h02);
    $display("dc offset done");
    acc(1, 8'h23, 8'h03);
    s.pwm_full_duty = 1;
    for (int i = 0; i < 3; i++) begin
      rd(8'h32, 8'h00);
      s.pwm_cycle_tick = 1;
      @(negedge ref_clk) s.pwm_cycle_tick = 0;
    end
    repeat (3) @(negedge ref_clk);
    rd(8'h32, 8'h02);
    acc(1, 8'h34, 8'h01);
    s.pwm_full_duty = 0;
    rd(8'h32, 8'h00);
    $display("clip done");
    acc(1, 8'h34, 8'h02);
    {s.overcurrent_trip_lo, s.overcurrent_trip_hi} = 2'b11;
    @(negedge ref_clk) {s.overcurrent_trip_lo, s.overcurrent_trip_hi} = 2'b00;
    acc(1, 8'h21, 8'h80);
    chk("diag", 1, diag_st);
    chk("drive", drive_hiz, 8'(drv));
    @(negedge ref_clk) {dd, dl} = 2'b11;
    @(negedge ref_clk) {dd, dl} = 2'b00;
    chk("diag", 1, diag_st);
    @(negedge ref_clk) dd = 1;
    @(negedge ref_clk) dd = 0;
    repeat (2) @(negedge ref_clk);
    chk("drive", drive_play, 8'(drv));
    $display("diag done");
    acc(1, 8'h21, 8'h08);
    {s.thermal_shutdown, s.supply_high} = 2'b11;
    @(negedge ref_clk) {s.thermal_shutdown, s.supply_high} = 2'b00;
    chk("drive", drive_hiz, 8'(drv));
    repeat (2) @(negedge ref_clk);
    chk("drive", drive_play, 8'(drv));
    chk("err", 1, eo);
    rd(8'h30, 8'h0c);
    $display("thermal done");
    conclude();
  end
endmodule // tb_amp_protection_fault_monitor
